// ===== hw/signal_level_detect_control.sv
`timescale 1ns/1ns
`default_nettype none

module signal_level_detect_control
   import level_detect_pkg::*;
(
   input  wire logic       ref_clk_in,
   input  wire logic       rst_n_in,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   input  wire logic       address_select_in,
   input  wire logic       level_below_threshold_in,
   input  wire logic       level_above_double_in,
   input  wire logic [7:0] amplitude_mv_in,
   output var  logic       sda_out,
   output var  logic       sda_oe_n_out,
   output var  logic       signal_absent_alarm_out,
   output var  logic       level_detector_power_down_out,
   output var  logic [7:0] threshold_mv_out
);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   logic [4:0] sync_bus;
   logic       scl_s;
   logic       sda_s;
   logic       addr_s;
   logic       below_s;
   logic       above_s;

   two_flop_sync #(.width(5)) pin_sync (
      .ref_clk_in (ref_clk_in),
      .rst_n_in   (rst_n_in),
      .async_in   ({scl_in, sda_in, address_select_in, level_below_threshold_in, level_above_double_in}),
      .sync_out   (sync_bus)
   );

   assign scl_s   = sync_bus[4];
   assign sda_s   = sync_bus[3];
   assign addr_s  = sync_bus[2];
   assign below_s = sync_bus[1];
   assign above_s = sync_bus[0];

   ////////////////////////////////////////////////////////////////////////////
   // serial slave

   typedef enum {s_idle, s_addr, s_addr_ack, s_sub, s_sub_ack, s_wr, s_wr_ack, s_rd, s_rd_ack} port_state_t;

   port_state_t state_reg;
   logic        scl_d_reg;
   logic        sda_d_reg;
   logic [7:0]  shift_reg;
   logic [7:0]  tx_reg;
   logic [3:0]  count_reg;
   logic        read_reg;
   logic        more_reg;
   logic [7:0]  pointer_reg;
   logic        wr_en_reg;
   logic [7:0]  wr_addr_reg;
   logic [7:0]  wr_data_reg;
   logic [7:0]  config_reg;
   logic [7:0]  data_reg;
   logic [7:0]  control_reg;

   wire         scl_rise    = scl_s & ~scl_d_reg;
   wire         scl_fall    = ~scl_s & scl_d_reg;
   wire         start_seen  = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
   wire         stop_seen   = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
   wire         byte_done   = scl_fall && (count_reg == bits_per_byte);
   wire [7:0]   shift_next  = {shift_reg[6:0], sda_s};
   wire         addr_match  = (shift_reg[7:1] == {slave_address_upper, addr_s});
   wire [7:0]   pointer_inc = pointer_reg + 8'h01;

   function automatic logic [7:0] read_byte(input logic [7:0] addr);
      if (addr == detector_config_offset)
         return config_reg;
      else if (addr == level_data_offset)
         return data_reg;
      else if (addr == level_control_offset)
         return control_reg;
      else
         return unmapped_read_value;
   endfunction

   wire [7:0]   read_first  = read_byte(pointer_reg);
   wire [7:0]   read_next   = read_byte(pointer_inc);

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_reg    <= s_idle;
         scl_d_reg    <= 1'b1;
         sda_d_reg    <= 1'b1;
         shift_reg    <= 8'h00;
         tx_reg       <= 8'h00;
         count_reg    <= 4'h0;
         read_reg     <= 1'b0;
         more_reg     <= 1'b0;
         pointer_reg  <= 8'h00;
         wr_en_reg    <= 1'b0;
         wr_addr_reg  <= 8'h00;
         wr_data_reg  <= 8'h00;
         sda_oe_n_out <= 1'b1;
         sda_out      <= 1'b0;
      end else begin
         scl_d_reg <= scl_s;
         sda_d_reg <= sda_s;
         wr_en_reg <= 1'b0;
         sda_out   <= 1'b0;
         if (start_seen) begin
            state_reg    <= s_addr;
            count_reg    <= 4'h0;
            sda_oe_n_out <= 1'b1;
         end else if (stop_seen) begin
            state_reg    <= s_idle;
            sda_oe_n_out <= 1'b1;
         end else begin
            unique case (state_reg)
               s_idle: begin
               end
               s_addr, s_sub, s_wr: begin
                  if (scl_rise) begin
                     shift_reg <= shift_next;
                     count_reg <= count_reg + 4'h1;
                  end
                  if (byte_done) begin
                     sda_oe_n_out <= 1'b0;
                     if (state_reg == s_addr) begin
                        // no ack and stay off the bus when another slave is addressed
                        sda_oe_n_out <= ~addr_match;
                        read_reg     <= shift_reg[0];
                        state_reg    <= addr_match ? s_addr_ack : s_idle;
                     end else if (state_reg == s_sub) begin
                        pointer_reg <= shift_reg;
                        state_reg   <= s_sub_ack;
                     end else begin
                        wr_en_reg   <= 1'b1;
                        wr_addr_reg <= pointer_reg;
                        wr_data_reg <= shift_reg;
                        state_reg   <= s_wr_ack;
                     end
                  end
               end
               s_addr_ack, s_sub_ack, s_wr_ack: begin
                  if (scl_fall) begin
                     count_reg <= 4'h0;
                     sda_oe_n_out <= 1'b1;
                     if (state_reg == s_wr_ack)
                        pointer_reg <= pointer_inc;
                     if (state_reg == s_addr_ack && read_reg) begin
                        tx_reg       <= read_first;
                        sda_oe_n_out <= read_first[7];
                        count_reg    <= 4'h1;
                        state_reg    <= s_rd;
                     end else begin
                        state_reg <= (state_reg == s_addr_ack) ? s_sub : s_wr;
                     end
                  end
               end
               s_rd: begin
                  if (byte_done) begin
                     sda_oe_n_out <= 1'b1;
                     state_reg    <= s_rd_ack;
                  end else if (scl_fall) begin
                     tx_reg       <= {tx_reg[6:0], 1'b0};
                     sda_oe_n_out <= tx_reg[6];
                     count_reg    <= count_reg + 4'h1;
                  end
               end
               s_rd_ack: begin
                  if (scl_rise)
                     more_reg <= ~sda_s;
                  if (scl_fall) begin
                     if (more_reg) begin
                        pointer_reg  <= pointer_inc;
                        tx_reg       <= read_next;
                        sda_oe_n_out <= read_next[7];
                        count_reg    <= 4'h1;
                        state_reg    <= s_rd;
                     end else begin
                        state_reg <= s_idle;
                     end
                  end
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register file and level-detector control

   logic       armed_reg;
   logic [2:0] armed_select_reg;

   wire [2:0] new_select   = wr_data_reg[target_select_lsb +: target_select_width];
   wire       ctrl_write   = wr_en_reg && (wr_addr_reg == level_control_offset);
   wire       data_write   = wr_en_reg && (wr_addr_reg == level_data_offset);
   wire       config_write = wr_en_reg && (wr_addr_reg == detector_config_offset);
   wire       strobe_rise  = ctrl_write && !control_reg[strobe_bit] && wr_data_reg[strobe_bit];
   wire       strobe_fall  = ctrl_write && control_reg[strobe_bit] && !wr_data_reg[strobe_bit];
   // a strobe rise then fall is needed before acting, with the same select value at the rising write and the falling write
   wire       toggle_done  = strobe_fall && armed_reg && (armed_select_reg == new_select);
   wire       load_thresh  = toggle_done && (new_select == target_threshold);
   wire       measure_fire = toggle_done && (new_select == target_measure);
   wire       powered_down = config_reg[power_down_bit];
   // out-of-range requests saturate at the top of the span
   wire [7:0] thresh_clamp = (data_reg > threshold_max_mv) ? threshold_max_mv : data_reg;
   wire [7:0] thresh_next  = (thresh_clamp >= threshold_coarse_mv) ?
                             {thresh_clamp[7:1], 1'b0} : thresh_clamp;
   // amplitude arrives as an absolute figure, upstream of any slice offset
   wire [7:0] measure_next = powered_down ? 8'h00 : amplitude_mv_in;

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         config_reg       <= detector_config_reset;
         control_reg      <= level_control_reset;
         data_reg         <= level_data_reset;
         armed_reg        <= 1'b0;
         armed_select_reg <= 3'h0;
         threshold_mv_out <= threshold_reset;
      end else begin
         if (config_write)
            config_reg <= wr_data_reg & (8'h01 << power_down_bit);
         if (ctrl_write)
            control_reg <= wr_data_reg;
         if (strobe_rise) begin
            armed_reg        <= 1'b1;
            armed_select_reg <= new_select;
         end else if (strobe_fall) begin
            armed_reg <= 1'b0;
         end
         if (measure_fire)
            data_reg <= measure_next;
         else if (data_write)
            data_reg <= wr_data_reg;
         if (load_thresh)
            threshold_mv_out <= thresh_next;
      end
   end

   assign level_detector_power_down_out = config_reg[power_down_bit];

   ////////////////////////////////////////////////////////////////////////////
   // alarm with hysteresis

   // set wins over clear so a dip is never masked by a stale above flag
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in)
         signal_absent_alarm_out <= 1'b0;
      else if (powered_down)
         signal_absent_alarm_out <= 1'b0;
      else if (below_s)
         signal_absent_alarm_out <= 1'b1;
      else if (above_s)
         signal_absent_alarm_out <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);

   alarm_set_a: assert property (below_s && !powered_down |=> signal_absent_alarm_out)
      else $error("alarm did not set below threshold");
   alarm_hold_a: assert property (signal_absent_alarm_out && !above_s && !powered_down
                                  |=> signal_absent_alarm_out)
      else $error("alarm released before twice threshold");
   alarm_source_a: assert property ($rose(signal_absent_alarm_out) |-> $past(below_s))
      else $error("alarm rose without synchronised comparator");
   power_down_a: assert property (config_write |=> level_detector_power_down_out
                                  == $past(wr_data_reg[power_down_bit]))
      else $error("power-down bit not taken");
   thresh_range_a: assert property (threshold_mv_out <= threshold_max_mv)
      else $error("threshold above span");
   thresh_coarse_a: assert property (threshold_mv_out >= threshold_coarse_mv |-> !threshold_mv_out[0])
      else $error("coarse threshold has odd step");
   thresh_cause_a: assert property (!$stable(threshold_mv_out) |-> $past(load_thresh))
      else $error("threshold changed without select-1 toggle");
   measure_load_a: assert property (measure_fire |=> data_reg == $past(measure_next))
      else $error("measurement not loaded at strobe fall");
   data_cause_a: assert property (!$stable(data_reg) |-> $past(measure_fire) || $past(data_write))
      else $error("data register changed without cause");

endmodule

`default_nettype wire

// ===== hw/level_detect_pkg.sv
`default_nettype none

package level_detect_pkg;

   // register offsets on the serial port
   localparam logic [7:0] detector_config_offset  = 8'h09;
   localparam logic [7:0] level_data_offset       = 8'h36;
   localparam logic [7:0] level_control_offset    = 8'h74;

   // field positions
   localparam int         power_down_bit          = 3;
   localparam int         strobe_bit              = 4;
   localparam int         target_select_lsb       = 0;
   localparam int         target_select_width     = 3;

   // target-select codes
   localparam logic [2:0] target_threshold        = 3'h1;
   localparam logic [2:0] target_measure          = 3'h7;

   // threshold range in millivolts
   localparam logic [7:0] threshold_max_mv        = 8'h80;
   localparam logic [7:0] threshold_coarse_mv     = 8'h40;

   // reset values
   localparam logic [7:0] detector_config_reset   = 8'h00;
   localparam logic [7:0] level_data_reset        = 8'h00;
   localparam logic [7:0] level_control_reset     = 8'h00;
   localparam logic [7:0] threshold_reset         = 8'h00;
   localparam logic [7:0] unmapped_read_value     = 8'h00;

   // serial port
   localparam logic [5:0] slave_address_upper     = 6'h20;
   localparam logic [3:0] bits_per_byte           = 4'h8;

endpackage

`default_nettype wire

// ===== hw/two_flop_sync.sv
`timescale 1ns/1ns
`default_nettype none

module two_flop_sync #(
   parameter int width = 1
) (
   input  wire logic             ref_clk_in,
   input  wire logic             rst_n_in,
   input  wire logic [width-1:0] async_in,
   output var  logic [width-1:0] sync_out
);

   logic [width-1:0] meta_reg;

   // meta_reg is read by sync_out only
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

endmodule

`default_nettype wire

// ===== sim/line_front_end_model.sv
`timescale 1ns/1ns
`default_nettype none

module line_front_end_model (
   input  wire logic [7:0] level_mv_in,
   input  wire logic [7:0] threshold_mv_in,
   output var  logic       below_out,
   output var  logic       above_double_out,
   output var  logic [7:0] amplitude_mv_out
);
   // ideal comparators; a real front end chatters near the trip points
   always_comb begin
      below_out        = {1'b0, level_mv_in} < {1'b0, threshold_mv_in};
      above_double_out = {1'b0, level_mv_in} >= {threshold_mv_in, 1'b0};
      amplitude_mv_out = level_mv_in;
   end
endmodule

`default_nettype wire

// ===== sim/signal_level_detect_control_tb.sv
`timescale 1ns/1ns
`default_nettype none

module signal_level_detect_control_tb
   import level_detect_pkg::*;
;
   localparam int half = 9;
   logic       ref_clk_in, rst_n_in, scl, sda_m, sda_o, sda_oe_n, alarm, pdn, below, above, k;
   logic [7:0] thr, level, amp, rd;
   int         miscompares, comparisons;
   wire        sda_line = sda_m & (sda_oe_n | sda_o);
   logic [7:0] dev_w = {slave_address_upper, 2'b00};
   logic [7:0] tv[7] = '{8'h00, 8'h3f, 8'h40, 8'h41, 8'h7f, 8'h80, 8'hff};
   // opens above twice the threshold so the alarm left over from the measurement test is cleared first
   logic [7:0] lv[6] = '{8'h5a, 8'h1e, 8'h3c, 8'h5a, 8'h3c, 8'h1e};
   logic       av[6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};

   signal_level_detect_control signal_level_detect_control_inst (
      .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda_line),
      .address_select_in(1'b0), .level_below_threshold_in(below), .level_above_double_in(above),
      .amplitude_mv_in(amp), .sda_out(sda_o), .sda_oe_n_out(sda_oe_n),
      .signal_absent_alarm_out(alarm), .level_detector_power_down_out(pdn), .threshold_mv_out(thr));

   line_front_end_model line_front_end_model_inst (
      .level_mv_in(level), .threshold_mv_in(thr), .below_out(below),
      .above_double_out(above), .amplitude_mv_out(amp));

   initial begin
      ref_clk_in = 1'b0;
      forever #25 ref_clk_in = ~ref_clk_in;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_in);
   endtask

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic summarize();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // sda moves only well inside scl low, never at the scl fall itself
   task automatic clk_bit(input logic d, output logic s);
      scl <= 1'b0;
      tick(3);
      sda_m <= d;
      tick(half);
      scl <= 1'b1;
      tick(half);
      s = sda_line;
   endtask

   task automatic start();
      sda_m <= 1'b1;
      scl <= 1'b1;
      tick(half);
      sda_m <= 1'b0;
      tick(half);
   endtask

   task automatic stop();
      logic s;
      clk_bit(1'b0, s);
      sda_m <= 1'b1;
      tick(half);
   endtask

   task automatic send_byte(input logic [7:0] b, output logic ok);
      logic s;
      for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
      clk_bit(1'b1, s);
      ok = ~s;
   endtask

   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      logic k1, k2, k3;
      start();
      send_byte(dev_w, k1);
      send_byte(a, k2);
      send_byte(d, k3);
      stop();
      check("write acks", {5'h00, k1, k2, k3}, 8'h07);
   endtask

   task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
      logic k1, k2, k3, s;
      start();
      send_byte(dev_w, k1);
      send_byte(a, k2);
      stop();
      start();
      send_byte(dev_w | 8'h01, k3);
      for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
      clk_bit(1'b1, s);
      stop();
      check("read acks", {5'h00, k1, k2, k3}, 8'h07);
   endtask

   task automatic strobe_seq(input logic [7:0] c0, input logic [7:0] c1, input logic [7:0] c2);
      reg_write(level_control_offset, c0);
      reg_write(level_control_offset, c1);
      reg_write(level_control_offset, c2);
   endtask

   function automatic logic [7:0] thr_exp(input logic [7:0] v);
      if (v > threshold_max_mv) return threshold_max_mv;
      if (v >= threshold_coarse_mv) return {v[7:1], 1'b0};
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (90000) @(posedge ref_clk_in);
      miscompares++;
      $display("ERROR watchdog expected end seen hang");
      summarize();
   end

   initial begin
      rst_n_in = 1'b0;
      scl = 1'b1;
      sda_m = 1'b1;
      level = 8'h00;
      miscompares = 0;
      comparisons = 0;
      tick(16);
      rst_n_in <= 1'b1;
      tick(4);
      check("threshold", thr, threshold_reset);
      check("power down", {7'h00, pdn}, 8'h00);
      foreach (tv[i]) if (i < 4) begin
         reg_read(i == 3 ? 8'h50 : (i == 0 ? detector_config_offset : (i == 1 ? level_data_offset
                  : level_control_offset)), rd);
         check("reset value", rd, 8'h00);
      end
      start();
      send_byte(dev_w | 8'h02, k);
      stop();
      check("foreign address ack", {7'h00, k}, 8'h00);
      // auto-increment: write runs from an unmapped offset into the control register
      start();
      send_byte(dev_w, k);
      send_byte(8'h73, k);
      send_byte(8'h5a, k);
      send_byte(8'h06, k);
      stop();
      check("auto increment write ack", {7'h00, k}, 8'h01);
      start();
      send_byte(dev_w, k);
      send_byte(8'h73, k);
      stop();
      start();
      send_byte(dev_w | 8'h01, k);
      for (int i = 7; i >= 0; i--) clk_bit(1'b1, rd[i]);
      clk_bit(1'b0, k);
      check("auto increment read first", rd, unmapped_read_value);
      for (int i = 7; i >= 0; i--) clk_bit(1'b1, rd[i]);
      clk_bit(1'b1, k);
      stop();
      check("auto increment read next", rd, 8'h06);
      $display("test reset done");

      // threshold programming, including clamp and the coarse range
      foreach (tv[i]) begin
         reg_write(level_control_offset, 8'h21);
         reg_write(level_data_offset, tv[i]);
         reg_write(level_control_offset, 8'h31);
         reg_write(level_control_offset, 8'h21);
         check("threshold", thr, thr_exp(tv[i]));
         reg_read(level_data_offset, rd);
         check("data readback", rd, tv[i]);
      end
      reg_write(level_data_offset, 8'h10);
      strobe_seq(8'h22, 8'h32, 8'h22);
      check("threshold wrong select", thr, 8'h80);
      $display("test threshold done");

      level <= 8'h5a;
      strobe_seq(8'h07, 8'h17, 8'h17);
      reg_read(level_data_offset, rd);
      check("data before fall", rd, 8'h10);
      reg_write(level_control_offset, 8'h07);
      reg_read(level_data_offset, rd);
      check("measurement", rd, 8'h5a);
      level <= 8'h21;
      strobe_seq(8'h17, 8'h16, 8'h06);
      reg_read(level_data_offset, rd);
      check("measurement select change", rd, 8'h5a);
      reg_read(level_control_offset, rd);
      check("control readback", rd, 8'h06);
      $display("test measurement done");

      reg_write(level_data_offset, 8'h28);
      strobe_seq(8'h21, 8'h31, 8'h21);
      foreach (lv[i]) begin
         level <= lv[i];
         tick(10);
         check("alarm", {7'h00, alarm}, {7'h00, av[i]});
      end
      $display("test hysteresis done");

      reg_write(detector_config_offset, 8'h08);
      tick(10);
      check("power down", {7'h00, pdn}, 8'h01);
      check("alarm powered down", {7'h00, alarm}, 8'h00);
      reg_read(detector_config_offset, rd);
      check("config readback", rd, 8'h08);
      strobe_seq(8'h07, 8'h17, 8'h07);
      reg_read(level_data_offset, rd);
      check("measurement powered down", rd, 8'h00);
      reg_write(detector_config_offset, 8'h00);
      tick(10);
      check("power up", {6'h00, pdn, alarm}, 8'h01);
      $display("test power down done");
      summarize();
   end
endmodule

`default_nettype wire
